/* File: hw/scd_pkg.sv */
// Constants shared by the serial command decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package scd_pkg;
	// Reset values of the command-addressed registers.
	localparam logic [7:0] SETUP_RST = 8'h28;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// Command byte field positions.
	localparam int CONV_TEMP_BIT = 0;
	localparam int CONV_SCAN_LSB = 1;
	localparam int CONV_CHAN_LSB = 3;
	localparam int SETUP_PAIR_LSB = 0;
	localparam int SETUP_VREF_LSB = 2;
	localparam int SETUP_CLK_LSB = 4;
	localparam int AVG_EN_BIT = 4;
	localparam int RST_REQ_BIT = 2;
	localparam int RST_SLOW_BIT = 1;
	localparam int RST_BIAS_BIT = 0;
	// Command codes and leading patterns.
	localparam logic [7:0] CMD_GPIO_CFG = 8'h03;
	localparam logic [7:0] CMD_GPIO_WR = 8'h02;
	localparam logic [7:0] CMD_GPIO_RD = 8'h01;
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [1:0] PAIR_UNI = 2'h2;
	localparam logic [1:0] PAIR_BIP = 2'h3;
	localparam logic [1:0] CLK_MODE_RISE = 2'h3;
	// Frame geometry.
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int OUT_W = 16;
	localparam int RES_W = 10;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [1:0] SUB_BITS = 2'h0;

	typedef enum logic [3:0] {
		SCD_K_NOP, SCD_K_CONV, SCD_K_SETUP, SCD_K_AVG, SCD_K_DAC,
		SCD_K_RESET, SCD_K_GCFG, SCD_K_GWR, SCD_K_GRD
	} scd_kind_e;

	// Frame states, Gray coded along idle, command, data.
	typedef enum logic [1:0] {
		SCD_S_IDLE = 2'b00,
		SCD_S_CMD = 2'b01,
		SCD_S_DATA = 2'b11
	} scd_state_e;
endpackage

/* File: hw/scd_sync.sv */
// Two flip-flop synchroniser, one lane per bit.
// Assumes asynchronous inputs and the block clock.
`timescale 1ns/1ps
module scd_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Lanes
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_lane
			logic meta_r;
			logic hold_r;
			// Reset to one so an idle select and clock look released.
			always_ff @(posedge clock)
			begin
				if (sys_rst)
				begin
					meta_r <= 1'b1;
					hold_r <= 1'b1;
				end
				else
				begin
					meta_r <= async_in[i];
					hold_r <= meta_r;
				end
			end
			assign sync_out[i] = hold_r;
		end
	endgenerate
endmodule // scd_sync

/* File: hw/scd_shift_out.sv */
// Serial output shifter: loads a word and moves it out most significant bit first.
// Assumes load and shift are one-cycle strobes from the block clock domain.
`timescale 1ns/1ps
module scd_shift_out (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic clear,
	input wire logic load,
	input wire logic [scd_pkg::OUT_W-1:0] load_word,
	input wire logic shift,
	// Serial bit
	output logic dout_bit
);
	logic [scd_pkg::OUT_W-1:0] sr_r;
	logic [scd_pkg::OUT_W-1:0] sr_nxt;

	// Zeros fill in behind the word, so an over-long read returns zero.
	assign sr_nxt = load ? load_word : (shift ? {sr_r[scd_pkg::OUT_W-2:0], 1'b0} : sr_r);

	always_ff @(posedge clock)
	begin
		if (sys_rst || clear)
			sr_r <= scd_pkg::WORD_RST;
		else
			sr_r <= sr_nxt;
	end

	assign dout_bit = sr_r[scd_pkg::OUT_W-1];
endmodule // scd_shift_out

/* File: hw/scd_decoder.sv */
// Serial slave port and command byte decoder of a combined converter device.
// Assumes chip select, serial clock and data input arrive asynchronously from a master.
// Notes on behaviour
// - Works idle low or high, polarity equals phase.
// - Sample data input on falling clock edges.
// - Output changes on falling edge, modes 00-10.
// - Output changes on rising edge in mode 11.
// - Bipolar and temperature results two's complement.
// - Select falling edge starts a transaction.
// - Command byte first, eight bits, MSB first.
// - Command picks target and 8/16/24 bits.
// - Select high resets counters and partial command.
// - Bit 7 set writes conversion register.
// - Pattern 01 writes setup register fields.
// - Pair mode access takes one following byte.
// - Pattern 001 writes averaging register.
// - Pattern 00001 writes reset register.
// - Pattern 0001 then two converter-output bytes.
// - GPIO configure, write, read codes; zero nop.
// - GPIO write takes exactly one byte.
// - Without GPIO, accept GPIO commands, do nothing.
// - Output released while select is high.
// - Setup resets to 0010 1000, others zero.
// - Results are two bytes, four leading zeros.
`timescale 1ns/1ps
module scd_decoder #(
	parameter bit HAS_GPIO = 1'b1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout_o,
	output logic dout_oe,
	// Result source
	input wire logic result_valid,
	input wire logic [scd_pkg::RES_W-1:0] result_value,
	input wire logic result_signed,
	output logic result_taken,
	// Configuration registers
	output logic [7:0] conversion_control,
	output logic [7:0] setup_control,
	output logic [7:0] averaging_control,
	output logic [7:0] reset_control,
	output logic [7:0] unipolar_pairs,
	output logic [7:0] bipolar_pairs,
	output logic conv_request,
	output logic reset_request,
	// Converter output interface
	output logic [15:0] dac_word,
	output logic dac_load,
	// General-purpose I/O
	output logic [7:0] gpio_config,
	output logic [7:0] gpio_out,
	input wire logic [3:0] gpio_in
);
	// Returns the kind of command for a byte.
	function automatic scd_pkg::scd_kind_e kind_of(input logic [7:0] c);
		if (c[7])
			kind_of = scd_pkg::SCD_K_CONV;
		else if (c[6])
			kind_of = scd_pkg::SCD_K_SETUP;
		else if (c[5])
			kind_of = scd_pkg::SCD_K_AVG;
		else if (c[4])
			kind_of = scd_pkg::SCD_K_DAC;
		else if (c[3])
			kind_of = scd_pkg::SCD_K_RESET;
		else if (c == scd_pkg::CMD_GPIO_CFG)
			kind_of = scd_pkg::SCD_K_GCFG;
		else if (c == scd_pkg::CMD_GPIO_WR)
			kind_of = scd_pkg::SCD_K_GWR;
		else if (c == scd_pkg::CMD_GPIO_RD)
			kind_of = scd_pkg::SCD_K_GRD;
		else
			kind_of = scd_pkg::SCD_K_NOP;
	endfunction

	// Number of data bytes that follow a command byte.
	function automatic logic [1:0] extra_of(input logic [7:0] c);
		scd_pkg::scd_kind_e k;
		k = kind_of(c);
		if (k == scd_pkg::SCD_K_DAC)
			extra_of = 2'd2;
		else if (k == scd_pkg::SCD_K_SETUP && c[scd_pkg::SETUP_PAIR_LSB+1])
			extra_of = 2'd1;
		else if (k == scd_pkg::SCD_K_GCFG || k == scd_pkg::SCD_K_GWR)
			extra_of = 2'd1;
		else
			extra_of = 2'd0;
	endfunction

	// Pin synchronisers.
	logic [2:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic din_s;

	scd_sync #(
		.W(3)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in({cs_n, sclk, din}),
		.sync_out(pins_s)
	);

	assign cs_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s = pins_s[0];

	// Edge detection on synchronised pins.
	logic sclk_d_r;
	logic cs_n_d_r;
	logic seen_fall_r;
	logic sclk_fall;
	logic sclk_rise;
	logic cs_fall;
	logic cs_high;

	assign sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s;
	assign sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s;
	assign cs_fall = cs_n_d_r & ~cs_n_s;
	assign cs_high = cs_n_s;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	// A rising edge counts only after a falling edge in the frame, so the
	// first bit is never skipped whichever way the clock idles.
	always_ff @(posedge clock)
	begin
		if (sys_rst || cs_high)
			seen_fall_r <= 1'b0;
		else if (sclk_fall)
			seen_fall_r <= 1'b1;
	end

	// Receive path.
	scd_pkg::scd_state_e state_r;
	scd_pkg::scd_state_e state_nxt;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_r;
	logic [7:0] rx_nxt;
	logic [7:0] cmd_r;
	logic [1:0] left_r;
	logic [1:0] left_nxt;
	logic [7:0] first_data_r;
	logic byte_done;
	logic cmd_done;
	logic data_done;
	scd_pkg::scd_kind_e cmd_kind;
	scd_pkg::scd_kind_e new_kind;

	assign rx_nxt = {rx_r[6:0], din_s};
	assign byte_done = sclk_fall && (bit_cnt_r == scd_pkg::LAST_BIT);
	assign cmd_done = byte_done && (state_r == scd_pkg::SCD_S_CMD);
	assign data_done = byte_done && (state_r == scd_pkg::SCD_S_DATA) && (left_r != 2'd0);
	assign new_kind = kind_of(rx_nxt);
	assign cmd_kind = kind_of(cmd_r);
	assign left_nxt = cmd_done ? extra_of(rx_nxt) : (data_done ? left_r - 2'd1 : left_r);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			scd_pkg::SCD_S_IDLE:
				if (cs_fall)
					state_nxt = scd_pkg::SCD_S_CMD;
			scd_pkg::SCD_S_CMD:
				if (cmd_done)
					state_nxt = scd_pkg::SCD_S_DATA;
			scd_pkg::SCD_S_DATA:
				state_nxt = scd_pkg::SCD_S_DATA;
			default:
				state_nxt = scd_pkg::SCD_S_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst || cs_high)
		begin
			state_r <= scd_pkg::SCD_S_IDLE;
			bit_cnt_r <= 3'h0;
			rx_r <= scd_pkg::ZERO_RST;
			left_r <= 2'd0;
		end
		else
		begin
			state_r <= state_nxt;
			left_r <= left_nxt;
			if (sclk_fall)
			begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				rx_r <= rx_nxt;
			end
		end
	end

	// The command byte and first data byte survive the frame for later decoding.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cmd_r <= scd_pkg::CMD_NOP;
			first_data_r <= scd_pkg::ZERO_RST;
		end
		else
		begin
			if (cmd_done)
				cmd_r <= rx_nxt;
			if (data_done && left_r == 2'd2)
				first_data_r <= rx_nxt;
		end
	end

	// Register writes.
	logic [7:0] conv_r;
	logic [7:0] setup_r;
	logic [7:0] avg_r;
	logic [7:0] rstc_r;
	logic [7:0] uni_r;
	logic [7:0] bip_r;
	logic [15:0] dac_r;
	logic [7:0] gcfg_r;
	logic [7:0] gout_r;
	logic conv_req_r;
	logic rst_req_r;
	logic dac_load_r;
	logic wr_conv;
	logic wr_setup;
	logic wr_avg;
	logic wr_rst;
	logic soft_rst;
	logic pair_byte;
	logic wr_uni;
	logic wr_bip;
	logic wr_dac;
	logic wr_gcfg;
	logic wr_gout;

	assign wr_conv = cmd_done && new_kind == scd_pkg::SCD_K_CONV;
	assign wr_setup = cmd_done && new_kind == scd_pkg::SCD_K_SETUP;
	assign wr_avg = cmd_done && new_kind == scd_pkg::SCD_K_AVG;
	assign wr_rst = cmd_done && new_kind == scd_pkg::SCD_K_RESET;
	assign soft_rst = wr_rst && rx_nxt[scd_pkg::RST_REQ_BIT];
	assign pair_byte = data_done && cmd_kind == scd_pkg::SCD_K_SETUP;
	assign wr_uni = pair_byte && cmd_r[1:0] == scd_pkg::PAIR_UNI;
	assign wr_bip = pair_byte && cmd_r[1:0] == scd_pkg::PAIR_BIP;
	assign wr_dac = data_done && left_r == 2'd1 && cmd_kind == scd_pkg::SCD_K_DAC;
	assign wr_gcfg = HAS_GPIO && data_done && cmd_kind == scd_pkg::SCD_K_GCFG;
	assign wr_gout = HAS_GPIO && data_done && cmd_kind == scd_pkg::SCD_K_GWR;

	// A reset command with bit 2 set returns the converter settings to their power-up values.
	always_ff @(posedge clock)
	begin
		if (sys_rst || soft_rst)
		begin
			conv_r <= scd_pkg::ZERO_RST;
			setup_r <= scd_pkg::SETUP_RST;
			avg_r <= scd_pkg::ZERO_RST;
			uni_r <= scd_pkg::ZERO_RST;
			bip_r <= scd_pkg::ZERO_RST;
		end
		else
		begin
			if (wr_conv)
				conv_r <= rx_nxt;
			if (wr_setup)
				setup_r <= rx_nxt;
			if (wr_avg)
				avg_r <= rx_nxt;
			if (wr_uni)
				uni_r <= rx_nxt;
			if (wr_bip)
				bip_r <= rx_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			rstc_r <= scd_pkg::ZERO_RST;
			dac_r <= scd_pkg::WORD_RST;
			gcfg_r <= scd_pkg::ZERO_RST;
			gout_r <= scd_pkg::ZERO_RST;
			conv_req_r <= 1'b0;
			rst_req_r <= 1'b0;
			dac_load_r <= 1'b0;
		end
		else
		begin
			conv_req_r <= wr_conv;
			rst_req_r <= soft_rst;
			dac_load_r <= wr_dac;
			if (wr_rst)
				rstc_r <= rx_nxt;
			if (wr_dac)
				dac_r <= {first_data_r, rx_nxt};
			if (wr_gcfg)
				gcfg_r <= rx_nxt;
			if (wr_gout)
				gout_r <= rx_nxt;
		end
	end

	// Transmit path.
	logic [scd_pkg::RES_W-1:0] res_fmt;
	logic [scd_pkg::OUT_W-1:0] res_word;
	logic [scd_pkg::OUT_W-1:0] gpio_word;
	logic gpio_rd;
	logic rise_mode;
	logic tx_shift;
	logic tx_load;
	logic [scd_pkg::OUT_W-1:0] tx_word;

	// The engine gives offset binary; flipping the top bit yields two's complement.
	assign res_fmt = result_signed ? {~result_value[scd_pkg::RES_W-1], result_value[scd_pkg::RES_W-2:0]}
		: result_value;
	assign res_word = result_valid ? {scd_pkg::LEAD_ZEROS, res_fmt, scd_pkg::SUB_BITS}
		: scd_pkg::WORD_RST;
	assign gpio_rd = HAS_GPIO && cmd_done && new_kind == scd_pkg::SCD_K_GRD;
	assign gpio_word = {gpio_in, 12'h000};
	assign rise_mode = setup_r[scd_pkg::SETUP_CLK_LSB +: 2] == scd_pkg::CLK_MODE_RISE;
	assign tx_shift = rise_mode ? (sclk_rise && seen_fall_r) : sclk_fall;
	assign tx_load = cs_fall || gpio_rd;
	assign tx_word = gpio_rd ? gpio_word : res_word;

	scd_shift_out u_tx (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(cs_high),
		.load(tx_load),
		.load_word(tx_word),
		.shift(tx_shift),
		.dout_bit(dout_o)
	);

	// Output enable follows the synchronised select; the pin floats while it is high.
	assign dout_oe = ~cs_n_s;
	assign result_taken = cs_fall && result_valid;

	assign conversion_control = conv_r;
	assign setup_control = setup_r;
	assign averaging_control = avg_r;
	assign reset_control = rstc_r;
	assign unipolar_pairs = uni_r;
	assign bipolar_pairs = bip_r;
	assign conv_request = conv_req_r;
	assign reset_request = rst_req_r;
	assign dac_word = dac_r;
	assign dac_load = dac_load_r;
	assign gpio_config = gcfg_r;
	assign gpio_out = gout_r;
endmodule // scd_decoder

/* File: bench/scd_chk.sv */
// Concurrent checks on the serial command decoder ports.
// Assumes it is bound to scd_decoder and sees only that module's ports.
`timescale 1ns/1ps
module scd_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic dout_o,
	input wire logic dout_oe,
	// Result source
	input wire logic result_valid,
	input wire logic result_taken,
	// Registers and pulses
	input wire logic [7:0] conversion_control,
	input wire logic [7:0] setup_control,
	input wire logic [7:0] reset_control,
	input wire logic conv_request,
	input wire logic reset_request,
	input wire logic dac_load
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	oe_off_a: assert property (cs_n [*4] |-> !dout_oe)
		else $error("serial output driven while deselected");
	oe_on_a: assert property (!cs_n [*4] |-> dout_oe)
		else $error("serial output not driven while selected");
	dout_idle_a: assert property (cs_n [*4] |-> !dout_o)
		else $error("output shifter not cleared by deselect");
	take_once_a: assert property (result_taken |-> result_valid && !cs_n ##1 !result_taken)
		else $error("result taken without a waiting result");
	rst_val_a: assert property (disable iff (1'b0) sys_rst |=> setup_control == 8'h28 && reset_control == 8'h00)
		else $error("register reset value wrong");
	cfg_quiet_a: assert property (cs_n [*4] |=> $stable(setup_control) && $stable(conversion_control))
		else $error("register changed while deselected");
	conv_once_a: assert property (conv_request |=> !conv_request)
		else $error("conversion request longer than one cycle");
	rst_req_a: assert property (reset_request |-> reset_control[2] ##1 !reset_request)
		else $error("reset request without its control bit");
	dac_once_a: assert property (dac_load |=> !dac_load)
		else $error("converter load longer than one cycle");
endmodule // scd_chk

bind scd_decoder scd_chk chk_u (.clock, .sys_rst, .cs_n, .dout_o, .dout_oe, .result_valid, .result_taken,
	.conversion_control, .setup_control, .reset_control, .conv_request, .reset_request, .dac_load);

/* File: bench/scd_master.sv */
// Serial bus master model that frames commands towards the decoder.
// Assumes the decoder oversamples the link with its own much faster clock.
`timescale 1ns/1ps
module scd_master (
	// Link pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Sends the top n bits of d with the clock idling at cpol; dout is taken 40 ns after each falling edge,
	// so the two output edge modes give different words.
	// Called on a rising block clock edge, every pin change lands at least a quarter nanosecond off any edge.
	task automatic xfer(input logic [23:0] d, input int n, input logic cpol, output logic [15:0] rx);
		rx = 16'h0000;
		#1.25 sclk = cpol;
		#20 cs_n = 1'b0;
		#50;
		for (int i = 0; i < n; i++)
		begin
			din = d[23 - i];
			#22.5 sclk = ~sclk;
			if (cpol)
			begin
				#40 rx = {rx[14:0], dout};
				#22.5 sclk = 1'b1;
				#40;
			end
			else
			begin
				#62.5 sclk = 1'b0;
				#40 rx = {rx[14:0], dout};
			end
		end
		cs_n = 1'b1;
		din = ~din;
		#100;
	endtask
endmodule // scd_master

/* File: bench/testbench.sv */
// Self-checking bench for the serial command decoder.
// Assumes scd_master drives the link and scd_chk is bound to the design.
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic cs_n, sclk, din, dout_o, dout_oe, result_taken, conv_request, reset_request, dac_load;
	logic result_valid = 1'b0;
	logic result_signed = 1'b0;
	logic [9:0] result_value = 10'h000;
	logic [3:0] gpio_in = 4'h9;
	logic [7:0] conversion_control, setup_control, averaging_control, reset_control;
	logic [7:0] unipolar_pairs, bipolar_pairs, gpio_config, gpio_out;
	logic [15:0] dac_word;
	int n_fail = 0;
	int check_count = 0;
	int n_conv = 0;
	int n_dac = 0;
	int n_taken = 0;
	int n_rreq = 0;
	logic [7:0] gpio_config_bare, gpio_out_bare;
	wire dout_w = dout_oe ? dout_o : 1'bz;

	scd_decoder dut_u (.clock, .sys_rst, .cs_n, .sclk, .din, .dout_o, .dout_oe, .result_valid, .result_value,
		.result_signed, .result_taken, .conversion_control, .setup_control, .averaging_control, .reset_control,
		.unipolar_pairs, .bipolar_pairs, .conv_request, .reset_request, .dac_word, .dac_load, .gpio_config,
		.gpio_out, .gpio_in);
	scd_master m_u (.cs_n, .sclk, .din, .dout(dout_w));
	// A copy without general-purpose I/O hears the same link and must leave those registers alone.
	scd_decoder #(
		.HAS_GPIO(1'b0)
	) dut_bare_u (.clock, .sys_rst, .cs_n, .sclk, .din, .dout_o(), .dout_oe(), .result_valid, .result_value,
		.result_signed, .result_taken(), .conversion_control(), .setup_control(), .averaging_control(),
		.reset_control(), .unipolar_pairs(), .bipolar_pairs(), .conv_request(), .reset_request(),
		.dac_word(), .dac_load(), .gpio_config(gpio_config_bare), .gpio_out(gpio_out_bare), .gpio_in);

	initial forever #4 clock = ~clock;
	always @(posedge clock)
	begin
		if (conv_request === 1'b1) n_conv++;
		if (dac_load === 1'b1) n_dac++;
		if (result_taken === 1'b1) n_taken++;
		if (reset_request === 1'b1) n_rreq++;
	end

	task chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task rd(input logic [23:0] d, input int n, input logic cpol, output logic [15:0] rx);
		@(posedge clock);
		m_u.xfer(d, n, cpol, rx);
	endtask
	task wr(input logic [23:0] d, input int n);
		logic [15:0] rx;
		rd(d, n, 1'b0, rx);
	endtask

	task t_reset_vals;
		chk({setup_control, conversion_control, averaging_control}, 24'h28_0000);
		chk({reset_control, unipolar_pairs, bipolar_pairs}, 24'h00_0000);
		chk({dac_word, gpio_out}, 24'h00_0000);
	endtask
	task t_setup;
		wr(24'h6A_A500, 16);
		wr(24'h6B_5A00, 16);
		chk({setup_control, unipolar_pairs, bipolar_pairs}, 24'h6B_A55A);
	endtask
	// A half command is cut off; a stale bit count would merge it into the next byte.
	task t_abort;
		wr(24'h60_0000, 4);
		wr(24'h3A_0000, 8);
		chk({setup_control, averaging_control}, 24'h00_6B3A);
	endtask
	task t_conv;
		wr(24'hB7_0000, 8);
		chk(conversion_control, 24'h00_00B7);
		chk(24'(n_conv), 24'h00_0001);
	endtask
	task t_dac;
		wr(24'h1F_1234, 24);
		chk(dac_word, 24'h00_1234);
		chk(24'(n_dac), 24'h00_0001);
	endtask
	// The read byte follows the command, so the pin levels land in samples 8 to 11 of sixteen.
	task t_gpio;
		logic [15:0] rx;
		wr(24'h03_0F00, 16);
		wr(24'h02_A500, 16);
		wr(24'h00_0000, 8);
		rd(24'h01_0000, 16, 1'b0, rx);
		chk(rx, 24'h00_0120);
		chk({gpio_config, gpio_out, setup_control}, 24'h0F_A56B);
		chk({gpio_config_bare, gpio_out_bare}, 24'h00_0000);
	endtask
	task t_result(input bit m11, input bit cpol);
		logic [15:0] rx;
		logic [15:0] w;
		if (m11) wr(24'h78_0000, 8);
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clock);
			result_valid <= 1'b1;
			result_signed <= s[0];
			result_value <= 10'h2A5;
			w = {4'h0, 10'h2A5 ^ {s[0], 9'h000}, 2'b00};
			rd(24'h00_0000, 16, cpol, rx);
			if (m11) chk(rx, w);
			else chk(rx[15:1], w[14:0]);
		end
		@(posedge clock);
		result_valid <= 1'b0;
	endtask
	task t_rstcmd;
		wr(24'h0F_0000, 8);
		chk({setup_control, averaging_control, conversion_control}, 24'h28_0000);
		chk({reset_control, unipolar_pairs, bipolar_pairs}, 24'h0F_0000);
		chk(24'(n_taken), 24'h00_0008);
		chk(24'(n_rreq), 24'h00_0001);
	endtask

	initial
	begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		t_reset_vals;
		t_setup;
		t_abort;
		t_conv;
		t_dac;
		t_gpio;
		t_result(1'b0, 1'b0);
		t_result(1'b0, 1'b1);
		t_result(1'b1, 1'b0);
		t_result(1'b1, 1'b1);
		t_rstcmd;
		finish_test;
	end
	// The whole sequence needs well under 100 us.
	initial
	begin
		#500_000;
		n_fail++;
		finish_test;
	end
endmodule // testbench
